// file: retimer_paging_pkg.sv
// package: register offsets, fields and driver encodings for the paging block
package retimer_paging_pkg;
  localparam int          NUM_CH         = 4;
  localparam logic [7:0]  OFF_SELECT     = 8'hFF;
  localparam logic [7:0]  OFF_DEEMPH     = 8'h15;
  localparam logic [7:0]  OFF_SWING      = 8'h2D;
  localparam logic [7:0]  OFF_ID         = 8'h00;
  localparam logic [7:0]  OFF_VERSION    = 8'h01;
  localparam int          BIT_SET_EN     = 2;
  localparam int          BIT_BCAST      = 3;
  localparam int          BIT_DEM_RANGE  = 6;
  localparam logic [7:0]  SELECT_RESET   = 8'h00;
  localparam logic [7:0]  CHREG_RESET    = 8'h00;
  localparam logic [7:0]  SHREG_RESET    = 8'h00;
  localparam logic [7:0]  SELECT_WMASK   = 8'h0F;
  // arbitrary neutral identity value
  localparam logic [7:0]  VERSION_CODE   = 8'hA5;
  // swing in tens of millivolts: code 0 is 60, step 10
  localparam logic [7:0]  SWING_BASE_10MV = 8'd60;
  localparam logic [7:0]  SWING_STEP_10MV = 8'd10;
  // de-emphasis magnitude in tenths of dB, indexed by {range, level}
  localparam logic [7:0] DEM_RANGE0 [8] = '{8'd0, 8'd15, 8'd28, 8'd35, 8'd45, 8'd56, 8'd75, 8'd120};
  localparam logic [7:0] DEM_RANGE1 [8] = '{8'd0, 8'd9, 8'd20, 8'd33, 8'd39, 8'd50, 8'd60, 8'd90};
endpackage

// file: retimer_register_paging.sv
// top: register paging and driver setting decode of a four-channel retimer
//
// Behaviour
// R01 - swing field bits 2:0 of 0x2d decodes 0.6 V up to 1.3 V in 0.1 V steps
// R02 - de-emphasis from level bits 2:0 and range bit 6 of 0x15; level 0 is 0 dB
// R03 - range one: levels 1..7 give -0.9 -2.0 -3.3 -3.9 -5.0 -6.0 -9.0 dB
// R04 - range zero: levels 1..7 give -1.5 -2.8 -3.5 -4.5 -5.6 -7.5 -12.0 dB
// R05 - writes to 0xff always update the shared select register
// R06 - set-enable zero steers all accesses to the shared set
// R07 - set-enable one steers accesses to channel set in select bits 1:0
// R08 - address 0x00 exists in shared and channel sets, read by steering
// R09 - each channel keeps its own copy of every channel register
// R10 - host uses read-modify-write for partial register changes
// R11 - host does not write undescribed reserved addresses; the bench writes and reads back offset 0x20
// R12 - broadcast and set-enable both one: writes update every channel set
// R13 - writes to read-only registers are ignored
// R14 - all registers are eight bits wide with eight-bit offsets
`timescale 1ns/1ns
module retimer_register_paging
  import retimer_paging_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic [7:0] ID_STRAP,
  output logic      [7:0] RDATA,
  output logic      [7:0] SELECT,
  output logic      [7:0] SWING_10MV   [NUM_CH],
  output logic      [7:0] DEEMPH_TENTH_DB [NUM_CH],
  output logic      [2:0] SWING_CODE   [NUM_CH],
  output logic      [3:0] DEEMPH_CODE  [NUM_CH]
);

  // all register state of the block
  typedef struct packed {
    logic [7:0]                    select_r;
    logic [255:0][7:0]             shared_r;
    logic [NUM_CH-1:0][255:0][7:0] chan_r;
    logic [7:0]                    rdata_r;
    logic [7:0]                    id_r;
  } state_t;

  // source of the next read data
  typedef enum logic [1:0] {
    SRC_HOLD,
    SRC_SELECT,
    SRC_SHARED,
    SRC_CHAN
  } rd_src_t;

  state_t            st_r;
  state_t            st_nxt;

  // select register fields
  logic              set_enable_bit;
  logic              broadcast_write_bit;
  logic [1:0]        target_channel_number;
  logic [7:0]        sel_wdata;

  // offset decode
  logic              hit_select;
  logic              hit_id;
  logic              hit_version;
  logic              hit_readonly;

  // write steering
  logic              wr_select;
  logic              wr_other;
  logic              wr_shared;
  logic              wr_any_chan;
  logic [NUM_CH-1:0] wr_chan;

  // read steering
  logic              rd_select;
  logic              rd_other;
  logic              rd_shared;
  logic              rd_chan;
  rd_src_t           rd_src;
  logic [7:0]        rd_shared_data;
  logic [7:0]        rd_chan_data;
  logic [7:0]        rd_data;

  // select register fields
  assign set_enable_bit        = st_r.select_r[BIT_SET_EN];
  assign broadcast_write_bit   = st_r.select_r[BIT_BCAST];
  assign target_channel_number = st_r.select_r[1:0];
  assign sel_wdata             = WDATA & SELECT_WMASK;

  // offset decode
  assign hit_select   = (ADDR == OFF_SELECT); // R05
  assign hit_id       = (ADDR == OFF_ID); // R08
  assign hit_version  = (ADDR == OFF_VERSION);
  assign hit_readonly = hit_id || hit_version; // R13

  // write steering, 0xff always targets the select register
  assign wr_select   = WR_EN && hit_select; // R05
  assign wr_other    = WR_EN && !hit_select;
  assign wr_shared   = wr_other && !set_enable_bit && !hit_readonly; // R06 R13
  assign wr_any_chan = wr_other && set_enable_bit; // R07

  // read steering
  assign rd_select = RD_EN && hit_select;
  assign rd_other  = RD_EN && !hit_select;
  assign rd_shared = rd_other && !set_enable_bit; // R06
  assign rd_chan   = rd_other && set_enable_bit; // R07

  // selected channel copy
  always_comb begin
    unique case (target_channel_number)
      2'h0: begin
        rd_chan_data = st_r.chan_r[0][ADDR]; // R07 R08
      end
      2'h1: begin
        rd_chan_data = st_r.chan_r[1][ADDR];
      end
      2'h2: begin
        rd_chan_data = st_r.chan_r[2][ADDR];
      end
      2'h3: begin
        rd_chan_data = st_r.chan_r[3][ADDR];
      end
    endcase
  end

  // shared copy, read-only codes in front of storage
  always_comb begin
    rd_shared_data = st_r.shared_r[ADDR];
    if (hit_id) begin
      rd_shared_data = st_r.id_r; // R08
    end else if (hit_version) begin
      rd_shared_data = VERSION_CODE;
    end
  end

  // read source choice
  always_comb begin
    rd_src = SRC_HOLD;
    if (rd_select) begin
      rd_src = SRC_SELECT; // R05
    end else if (rd_shared) begin
      rd_src = SRC_SHARED; // R06
    end else if (rd_chan) begin
      rd_src = SRC_CHAN; // R07
    end
  end

  // read data mux
  always_comb begin
    unique case (rd_src)
      SRC_HOLD: begin
        rd_data = st_r.rdata_r;
      end
      SRC_SELECT: begin
        rd_data = st_r.select_r;
      end
      SRC_SHARED: begin
        rd_data = rd_shared_data;
      end
      SRC_CHAN: begin
        rd_data = rd_chan_data;
      end
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.id_r = ID_STRAP;
    if (wr_select) begin
      st_nxt.select_r = sel_wdata; // R05
    end
    if (wr_shared) begin
      st_nxt.shared_r[ADDR] = WDATA; // R06 R13
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_chan[c]) begin
        st_nxt.chan_r[c][ADDR] = WDATA; // R09 R12 R14
      end
    end
    if (RD_EN) begin
      st_nxt.rdata_r = rd_data;
    end
  end

  // register update
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_r.select_r <= SELECT_RESET;
      st_r.shared_r <= {256{SHREG_RESET}};
      st_r.chan_r   <= {(NUM_CH * 256){CHREG_RESET}};
      st_r.rdata_r  <= 8'h00;
      st_r.id_r     <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA  = st_r.rdata_r;
  assign SELECT = st_r.select_r;

  // per channel write steering and driver decode
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    logic [7:0] swing_reg;
    logic [7:0] deemph_reg;
    logic [2:0] swing_field;
    logic [2:0] level_field;
    logic       range_field;
    logic [7:0] swing_dec;
    logic [7:0] deemph_dec;

    assign wr_chan[c]  = wr_any_chan && (broadcast_write_bit || target_channel_number == 2'(c)); // R07 R12
    assign swing_reg   = st_r.chan_r[c][OFF_SWING];
    assign deemph_reg  = st_r.chan_r[c][OFF_DEEMPH];
    assign swing_field = swing_reg[2:0]; // R01
    assign level_field = deemph_reg[2:0]; // R02
    assign range_field = deemph_reg[BIT_DEM_RANGE]; // R02

    // output swing, one step per code
    always_comb begin
      unique case (swing_field)
        3'h0: begin
          swing_dec = SWING_BASE_10MV; // R01
        end
        3'h1: begin
          swing_dec = 8'(SWING_BASE_10MV + SWING_STEP_10MV);
        end
        3'h2: begin
          swing_dec = 8'(SWING_BASE_10MV + 8'h02 * SWING_STEP_10MV);
        end
        3'h3: begin
          swing_dec = 8'(SWING_BASE_10MV + 8'h03 * SWING_STEP_10MV);
        end
        3'h4: begin
          swing_dec = 8'(SWING_BASE_10MV + 8'h04 * SWING_STEP_10MV);
        end
        3'h5: begin
          swing_dec = 8'(SWING_BASE_10MV + 8'h05 * SWING_STEP_10MV);
        end
        3'h6: begin
          swing_dec = 8'(SWING_BASE_10MV + 8'h06 * SWING_STEP_10MV);
        end
        3'h7: begin
          swing_dec = 8'(SWING_BASE_10MV + 8'h07 * SWING_STEP_10MV);
        end
      endcase
    end

    // de-emphasis magnitude by range and level
    always_comb begin
      unique case ({range_field, level_field})
        4'h0: begin
          deemph_dec = DEM_RANGE0[0]; // R02
        end
        4'h1: begin
          deemph_dec = DEM_RANGE0[1]; // R04
        end
        4'h2: begin
          deemph_dec = DEM_RANGE0[2];
        end
        4'h3: begin
          deemph_dec = DEM_RANGE0[3];
        end
        4'h4: begin
          deemph_dec = DEM_RANGE0[4];
        end
        4'h5: begin
          deemph_dec = DEM_RANGE0[5];
        end
        4'h6: begin
          deemph_dec = DEM_RANGE0[6];
        end
        4'h7: begin
          deemph_dec = DEM_RANGE0[7];
        end
        4'h8: begin
          deemph_dec = DEM_RANGE1[0]; // R02
        end
        4'h9: begin
          deemph_dec = DEM_RANGE1[1]; // R03
        end
        4'hA: begin
          deemph_dec = DEM_RANGE1[2];
        end
        4'hB: begin
          deemph_dec = DEM_RANGE1[3];
        end
        4'hC: begin
          deemph_dec = DEM_RANGE1[4];
        end
        4'hD: begin
          deemph_dec = DEM_RANGE1[5];
        end
        4'hE: begin
          deemph_dec = DEM_RANGE1[6];
        end
        4'hF: begin
          deemph_dec = DEM_RANGE1[7];
        end
      endcase
    end

    assign SWING_CODE[c]      = swing_field; // R01
    assign SWING_10MV[c]      = swing_dec; // R01
    assign DEEMPH_CODE[c]     = {range_field, level_field}; // R02
    assign DEEMPH_TENTH_DB[c] = deemph_dec; // R03 R04
  end

endmodule

// file: retimer_paging_sva.sv
// checker: select register, steering and driver decode properties
`timescale 1ns/1ns
module retimer_paging_sva
  import retimer_paging_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RESET,
  input wire logic       WR_EN,
  input wire logic       RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] ID_STRAP,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] SELECT,
  input wire logic [7:0] SWING_10MV      [NUM_CH],
  input wire logic [7:0] DEEMPH_TENTH_DB [NUM_CH],
  input wire logic [2:0] SWING_CODE      [NUM_CH],
  input wire logic [3:0] DEEMPH_CODE     [NUM_CH]
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  property p_sel;
    WR_EN && ADDR == OFF_SELECT |=> SELECT == ($past(WDATA) & SELECT_WMASK);
  endproperty
  a_sel: assert property (p_sel) else $error("select register not loaded from write data");

  property p_rdsel;
    RD_EN && ADDR == OFF_SELECT |=> RDATA == $past(SELECT);
  endproperty
  a_rdsel: assert property (p_rdsel) else $error("select register read back wrong");

  property p_sh;
    WR_EN && !SELECT[BIT_SET_EN] && ADDR != OFF_SELECT |=> $stable(SWING_CODE[0]);
  endproperty
  a_sh: assert property (p_sh) else $error("shared write reached a channel set");

  property p_ch;
    WR_EN && SELECT[3:0] == 4'h5 && ADDR == OFF_SWING |=> SWING_CODE[1] == $past(WDATA[2:0]);
  endproperty
  a_ch: assert property (p_ch) else $error("selected channel write lost");

  property p_id;
    RD_EN && !SELECT[BIT_SET_EN] && ADDR == OFF_ID |=> RDATA == $past(ID_STRAP, 2);
  endproperty
  a_id: assert property (p_id) else $error("shared copy of offset zero read wrong");

  property p_bc;
    WR_EN && SELECT[3:2] == 2'h3 && ADDR == OFF_SWING |=> SWING_CODE[3] == $past(WDATA[2:0]);
  endproperty
  a_bc: assert property (p_bc) else $error("broadcast write missed a channel");

  property p_sw;
    SWING_10MV[1] == 8'(8'h3C + 8'h0A * {5'h00, SWING_CODE[1]});
  endproperty
  a_sw: assert property (p_sw) else $error("swing decode off its step");

  property p_dm0;
    DEEMPH_CODE[2][2:0] == 3'h0 |-> DEEMPH_TENTH_DB[2] == 8'h00;
  endproperty
  a_dm0: assert property (p_dm0) else $error("level zero not zero de-emphasis");
endmodule

bind retimer_register_paging retimer_paging_sva u_sva (
  .CLOCK           (CLOCK),
  .RESET           (RESET),
  .WR_EN           (WR_EN),
  .RD_EN           (RD_EN),
  .ADDR            (ADDR),
  .WDATA           (WDATA),
  .ID_STRAP        (ID_STRAP),
  .RDATA           (RDATA),
  .SELECT          (SELECT),
  .SWING_10MV      (SWING_10MV),
  .DEEMPH_TENTH_DB (DEEMPH_TENTH_DB),
  .SWING_CODE      (SWING_CODE),
  .DEEMPH_CODE     (DEEMPH_CODE)
);

// file: retimer_host_model.sv
// host model: register reads and writes, one transfer at a time
`timescale 1ns/1ns
module retimer_host_model (
  input  wire logic       CLOCK,
  input  wire logic [7:0] RDATA,
  output logic            WR_EN,
  output logic            RD_EN,
  output logic      [7:0] ADDR,
  output logic      [7:0] WDATA
);

  initial begin
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR  = 8'h00;
    WDATA = 8'h00;
  end

  // one strobe cycle, then idle with scrambled address and data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    #1;
    WR_EN = w;
    RD_EN = !w;
    ADDR  = a;
    WDATA = d;
    @(posedge CLOCK);
    #1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR  = ~a;
    WDATA = ~d;
  endtask

  // partial change: read, alter masked bits, write back
  task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] cur;
    acc(1'b0, a, 8'h00);
    cur = RDATA;
    acc(1'b1, a, (cur & ~m) | (v & m));
  endtask
endmodule

// file: retimer_register_paging_tb_top.sv
// bench: paging, steering, reset and driver decode scenarios
`timescale 1ns/1ns
module retimer_register_paging_tb_top;
  import retimer_paging_pkg::*;

  logic         CLOCK;
  logic         RESET;
  logic         WR_EN;
  logic         RD_EN;
  logic [7:0]   ADDR;
  logic [7:0]   WDATA;
  logic [7:0]   ID_STRAP;
  logic [7:0]   RDATA;
  logic [7:0]   SELECT;
  logic [7:0]   SWING_10MV      [NUM_CH];
  logic [7:0]   DEEMPH_TENTH_DB [NUM_CH];
  logic [2:0]   SWING_CODE      [NUM_CH];
  logic [3:0]   DEEMPH_CODE     [NUM_CH];
  logic [127:0] dem_exp;
  int           bad_count;
  int           checks;

  initial begin
    CLOCK = 1'b0;
    forever begin
      #10 CLOCK = ~CLOCK;
    end
  end

  retimer_register_paging uut (
    .CLOCK           (CLOCK),
    .RESET           (RESET),
    .WR_EN           (WR_EN),
    .RD_EN           (RD_EN),
    .ADDR            (ADDR),
    .WDATA           (WDATA),
    .ID_STRAP        (ID_STRAP),
    .RDATA           (RDATA),
    .SELECT          (SELECT),
    .SWING_10MV      (SWING_10MV),
    .DEEMPH_TENTH_DB (DEEMPH_TENTH_DB),
    .SWING_CODE      (SWING_CODE),
    .DEEMPH_CODE     (DEEMPH_CODE)
  );

  retimer_host_model host (
    .CLOCK (CLOCK),
    .RDATA (RDATA),
    .WR_EN (WR_EN),
    .RD_EN (RD_EN),
    .ADDR  (ADDR),
    .WDATA (WDATA)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // select register, steering and offset zero in both sets
  task automatic t_pg;
    host.acc(1'b1, OFF_SELECT, 8'hF5);
    chk(SELECT, 8'h05);
    host.acc(1'b1, OFF_SWING, 8'h02);
    chk(SWING_10MV[1], 8'h50);
    chk(SWING_10MV[0], 8'h3C);
    host.acc(1'b1, OFF_ID, 8'h5E);
    host.acc(1'b0, OFF_ID, 8'h00);
    chk(RDATA, 8'h5E);
    host.acc(1'b0, OFF_SELECT, 8'h00);
    chk(RDATA, 8'h05);
    host.acc(1'b1, OFF_SELECT, 8'h00);
    host.acc(1'b1, OFF_ID, 8'hFF);
    host.acc(1'b0, OFF_ID, 8'h00);
    chk(RDATA, 8'h3C);
    host.acc(1'b1, OFF_VERSION, 8'h00);
    host.acc(1'b0, OFF_VERSION, 8'h00);
    chk(RDATA, VERSION_CODE);
    host.acc(1'b1, 8'h20, 8'h77);
    host.acc(1'b0, 8'h20, 8'h00);
    chk(RDATA, 8'h77);
    host.rmw(OFF_SELECT, 8'h07, 8'h06);
    chk(SELECT, 8'h06);
    host.acc(1'b0, 8'h20, 8'h00);
    chk(RDATA, 8'h00);
  endtask

  // broadcast writes through every swing and de-emphasis code
  task automatic t_dec;
    logic [2:0] lvl;
    host.acc(1'b1, OFF_SELECT, 8'h0C);
    for (int i = 0; i < 16; i++) begin
      lvl = i[2:0];
      host.acc(1'b1, OFF_DEEMPH, {1'b0, i[3], 3'h0, lvl});
      host.acc(1'b1, OFF_SWING, {5'h00, lvl});
      chk(DEEMPH_TENTH_DB[i % 4], dem_exp[8 * i +: 8]);
      chk({4'h0, DEEMPH_CODE[i % 4]}, {4'h0, i[3], lvl});
      chk(SWING_10MV[3 - i % 4], 8'(8'h3C + 8'h0A * lvl));
      chk({5'h00, SWING_CODE[i % 4]}, {5'h00, lvl});
    end
  endtask

  // reset in mid-run returns to shared steering and lowest settings
  task automatic t_rst;
    @(posedge CLOCK);
    #1;
    RESET = 1'b1;
    @(posedge CLOCK);
    #1;
    chk(SELECT, SELECT_RESET);
    chk(SWING_10MV[2], 8'h3C);
    chk(DEEMPH_TENTH_DB[2], 8'h00);
    @(posedge CLOCK);
    #1;
    RESET = 1'b0;
    host.acc(1'b0, 8'h20, 8'h00);
    chk(RDATA, 8'h00);
  endtask

  initial begin
    RESET     = 1'b1;
    ID_STRAP  = 8'h3C;
    bad_count = 0;
    checks    = 0;
    dem_exp   = 128'h5A3C322721140900784B382D231C0F00;
    repeat (2) @(posedge CLOCK);
    #1;
    RESET = 1'b0;
    t_pg;
    t_dec;
    t_rst;
    test_done;
  end

  // about 50 two-cycle transfers expected; wide margin
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
endmodule
